/* File: cpvdr_defines.svh */
/*
  Constants of the cable plug discovery responder: message codes,
  revision codes and reply timing.
  Assumes a 50 MHz system clock and is included by its bare name.
*/
`ifndef CPVDR_DEFINES_SVH
`define CPVDR_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and reply timing
// ----------------------------------------------------------------
`define CPVDR_CLK_MHZ 50
`define CPVDR_T_REPLY_MIN_US 750
`define CPVDR_T_REPLY_MAX_US 15000
`define CPVDR_REPLY_MIN_CYC (`CPVDR_T_REPLY_MIN_US * `CPVDR_CLK_MHZ)
`define CPVDR_REPLY_MAX_CYC (`CPVDR_T_REPLY_MAX_US * `CPVDR_CLK_MHZ)

// ----------------------------------------------------------------
// Structured message codes
// ----------------------------------------------------------------
`define CPVDR_CMD_DISC_ID 5'h01
`define CPVDR_CMD_DISC_SVID 5'h02
`define CPVDR_CMD_DISC_MODE 5'h03
`define CPVDR_CMD_ENTER 5'h04
`define CPVDR_CMD_EXIT 5'h05
`define CPVDR_REV_20 2'h1
`define CPVDR_MODE_NONE 3'h0

// ----------------------------------------------------------------
// Advertised identity, arbitrary neutral values
// ----------------------------------------------------------------
`define CPVDR_SVID_VALUE 16'h1234
`define CPVDR_NUM_MODES 3'h2

`endif

/* File: cpvdr_pkg.sv */
/*
  Types of the cable plug discovery responder.
  Assumes nothing of its surroundings.
*/
package cpvdr_pkg;

  typedef enum logic [1:0] {
    CPVDR_SOP = 2'h0,
    CPVDR_SOP_P = 2'h1,
    CPVDR_SOP_PP = 2'h2,
    CPVDR_SOP_OTHER = 2'h3
  } cpvdr_sop_type;

  typedef enum logic [1:0] {
    CPVDR_REQ = 2'h0,
    CPVDR_ACK = 2'h1,
    CPVDR_NAK = 2'h2,
    CPVDR_BUSY = 2'h3
  } cpvdr_ctype_type;

  typedef enum logic [1:0] {
    CPVDR_IDLE = 2'h0,
    CPVDR_ACKW = 2'h1,
    CPVDR_HOLD = 2'h3,
    CPVDR_SEND = 2'h2
  } cpvdr_state_type;

  typedef struct packed {
    cpvdr_sop_type sop;
    logic crc_ok;
    logic [1:0] rev;
    logic [4:0] cmd;
    cpvdr_ctype_type ctype;
    logic [15:0] svid;
    logic [2:0] obj_pos;
  } cpvdr_rx_type;

  typedef struct packed {
    cpvdr_sop_type sop;
    logic [1:0] rev;
    logic [4:0] cmd;
    cpvdr_ctype_type ctype;
    logic [15:0] svid;
    logic [2:0] obj_pos;
    logic modal;
    logic more_svids;
  } cpvdr_tx_type;

  typedef struct packed {
    cpvdr_state_type st;
    logic [19:0] cnt;
    cpvdr_rx_type req;
    cpvdr_tx_type rep;
    logic gcrc;
    logic txv;
    logic [2:0] ent_p;
    logic [2:0] ent_pp;
    logic dual_s1;
    logic dual_s2;
  } cpvdr_state_reg_type;

endpackage : cpvdr_pkg

/* File: cpvdr_responder.sv */
/*
  Message-level discovery responder of an electronically marked cable
  plug. Takes decoded requests from the physical layer, asks it for the
  GoodCRC and hands back one structured reply per accepted request.
  Assumes a physical layer on clk_sys that pulses rx_valid per decoded
  message, pulses gcrc_done at the last EOP bit of the GoodCRC and
  pulses tx_done once the reply has left. rst_n follows VCONN.
*/
// Operation
// - Revision 3.0 identity request gets a revision 2.0 ACK on SOP'.
// - Reserved revision request still gets a revision 2.0 ACK.
// - Discover Identity on SOP' is always answered with ACK.
// - Reply starts 750 us to 15 ms after GoodCRC ends.
// - Discover SVIDs ACK exactly when modal, otherwise NAK.
// - Discover Modes for a reported SVID is ACKed with its modes.
// - Enter Mode answered ACK or NAK; advertised modes accepted.
// - Exit Mode after an entered mode is always ACKed.
// - Second controller on SOP'' follows the same reply policy.
// - Losing VCONN returns to initial state, modes abandoned.
`timescale 1ns/1ns
`include "cpvdr_defines.svh"

module cpvdr_responder #(
  parameter int unsigned REPLY_MIN_CYC = `CPVDR_REPLY_MIN_CYC,
  parameter int unsigned REPLY_MAX_CYC = `CPVDR_REPLY_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dual_ctrl_present,
  input wire logic modal_supported,
  input wire logic rx_valid,
  input wire cpvdr_pkg::cpvdr_rx_type rx_msg,
  input wire logic gcrc_done,
  input wire logic tx_done,
  output logic gcrc_req,
  output logic tx_valid,
  output cpvdr_pkg::cpvdr_tx_type tx_msg,
  output logic [2:0] mode_entered_p,
  output logic [2:0] mode_entered_pp
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic svid_ok(input logic [15:0] svid);
    svid_ok = (svid == `CPVDR_SVID_VALUE);
  endfunction : svid_ok

  function automatic logic mode_ok(input logic [15:0] svid,
                                   input logic [2:0] pos);
    mode_ok = svid_ok(svid) && (pos != `CPVDR_MODE_NONE) &&
              (pos <= `CPVDR_NUM_MODES);
  endfunction : mode_ok

  localparam logic [19:0] MIN_LAST = 20'(REPLY_MIN_CYC - 1);

  cpvdr_pkg::cpvdr_state_reg_type q;
  cpvdr_pkg::cpvdr_state_reg_type d;
  logic take;
  logic [2:0] ent;
  logic [2:0] ent_new;

  // ----------------------------------------------------------------
  // Request filter
  // ----------------------------------------------------------------
  // plain SOP ignored
  always_comb begin
    take = rx_valid && rx_msg.crc_ok &&
           (rx_msg.ctype == cpvdr_pkg::CPVDR_REQ) &&
           ((rx_msg.sop == cpvdr_pkg::CPVDR_SOP_P) ||
            ((rx_msg.sop == cpvdr_pkg::CPVDR_SOP_PP) && q.dual_s2));
    ent = (q.req.sop == cpvdr_pkg::CPVDR_SOP_PP) ? q.ent_pp : q.ent_p;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ent_new = ent;
    d.gcrc = 1'b0;
    d.dual_s1 = dual_ctrl_present;
    d.dual_s2 = q.dual_s1;
    case (q.st)
      cpvdr_pkg::CPVDR_IDLE: begin
        if (take) begin
          d.req = rx_msg;
          d.gcrc = 1'b1;
          d.st = cpvdr_pkg::CPVDR_ACKW;
        end
      end
      cpvdr_pkg::CPVDR_ACKW: begin
        if (gcrc_done) begin
          d.st = cpvdr_pkg::CPVDR_HOLD;
          d.cnt = '0;
          d.rep.sop = q.req.sop;
          d.rep.rev = `CPVDR_REV_20;
          d.rep.cmd = q.req.cmd;
          d.rep.svid = q.req.svid;
          d.rep.obj_pos = q.req.obj_pos;
          d.rep.modal = modal_supported;
          d.rep.more_svids = 1'b0;
          d.rep.ctype = cpvdr_pkg::CPVDR_NAK;
          case (q.req.cmd)
            `CPVDR_CMD_DISC_ID: begin
              d.rep.ctype = cpvdr_pkg::CPVDR_ACK;
            end
            `CPVDR_CMD_DISC_SVID: begin
              if (modal_supported) begin
                d.rep.ctype = cpvdr_pkg::CPVDR_ACK;
                d.rep.svid = `CPVDR_SVID_VALUE;
              end
            end
            `CPVDR_CMD_DISC_MODE: begin
              if (modal_supported && svid_ok(q.req.svid)) begin
                d.rep.ctype = cpvdr_pkg::CPVDR_ACK;
                d.rep.obj_pos = `CPVDR_NUM_MODES;
              end
            end
            `CPVDR_CMD_ENTER: begin
              if (modal_supported && mode_ok(q.req.svid, q.req.obj_pos)) begin
                d.rep.ctype = cpvdr_pkg::CPVDR_ACK;
                ent_new = q.req.obj_pos;
              end
            end
            `CPVDR_CMD_EXIT: begin
              d.rep.ctype = cpvdr_pkg::CPVDR_ACK;
              ent_new = `CPVDR_MODE_NONE;
            end
            default: begin
              d.rep.ctype = cpvdr_pkg::CPVDR_NAK;
            end
          endcase
          if (q.req.sop == cpvdr_pkg::CPVDR_SOP_PP) begin
            d.ent_pp = ent_new;
          end else begin
            d.ent_p = ent_new;
          end
        end
      end
      cpvdr_pkg::CPVDR_HOLD: begin
        d.cnt = q.cnt + 20'h00001;
        if (q.cnt >= MIN_LAST) begin
          d.st = cpvdr_pkg::CPVDR_SEND;
          d.txv = 1'b1;
        end
      end
      cpvdr_pkg::CPVDR_SEND: begin
        if (tx_done) begin
          d.txv = 1'b0;
          d.st = cpvdr_pkg::CPVDR_IDLE;
        end
      end
      default: begin
        d.st = cpvdr_pkg::CPVDR_IDLE;
      end
    endcase
    if (!rst_n) begin
      d = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  assign gcrc_req = q.gcrc;
  assign tx_valid = q.txv;
  assign tx_msg = q.rep;
  assign mode_entered_p = q.ent_p;
  assign mode_entered_pp = q.ent_pp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // The wait counter keeps reply timing visible without long delays.
  logic [19:0] since_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || gcrc_done) begin
      since_q <= '0;
    end else if (since_q != 20'hFFFFF) begin
      since_q <= since_q + 20'h00001;
    end
  end

  sequence s_req;
    rx_valid && rx_msg.crc_ok && rx_msg.ctype == cpvdr_pkg::CPVDR_REQ;
  endsequence

  property p_timing;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(tx_valid) |-> (since_q >= 20'(REPLY_MIN_CYC)) &&
                          (since_q <= 20'(REPLY_MAX_CYC));
  endproperty
  a_timing: assert property (p_timing) else $error("reply timing");

  property p_rev;
    @(posedge clk_sys) disable iff (!rst_n)
      tx_valid |-> tx_msg.rev == `CPVDR_REV_20;
  endproperty
  a_rev: assert property (p_rev) else $error("reply revision");

  property p_id_ack;
    @(posedge clk_sys) disable iff (!rst_n)
      tx_valid && tx_msg.cmd == `CPVDR_CMD_DISC_ID |->
        tx_msg.ctype == cpvdr_pkg::CPVDR_ACK;
  endproperty
  a_id_ack: assert property (p_id_ack) else $error("identity not ACK");

  property p_svid;
    @(posedge clk_sys) disable iff (!rst_n)
      tx_valid && tx_msg.cmd == `CPVDR_CMD_DISC_SVID |->
        (tx_msg.ctype == cpvdr_pkg::CPVDR_ACK) == tx_msg.modal;
  endproperty
  a_svid: assert property (p_svid) else $error("SVID policy");

  property p_exit;
    @(posedge clk_sys) disable iff (!rst_n)
      tx_valid && tx_msg.cmd == `CPVDR_CMD_EXIT |->
        tx_msg.ctype == cpvdr_pkg::CPVDR_ACK;
  endproperty
  a_exit: assert property (p_exit) else $error("exit not ACK");

  property p_enter;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(tx_valid) && tx_msg.cmd == `CPVDR_CMD_ENTER &&
      tx_msg.ctype == cpvdr_pkg::CPVDR_ACK && tx_msg.sop ==
      cpvdr_pkg::CPVDR_SOP_P |-> mode_entered_p == tx_msg.obj_pos;
  endproperty
  a_enter: assert property (p_enter) else $error("mode not held");

  property p_sop_ignore;
    @(posedge clk_sys) disable iff (!rst_n)
      s_req and (q.st == cpvdr_pkg::CPVDR_IDLE) &&
      rx_msg.sop == cpvdr_pkg::CPVDR_SOP |=> !gcrc_req;
  endproperty
  a_sop_ignore: assert property (p_sop_ignore) else $error("SOP seen");

  // The reply may not start while the GoodCRC is still on the line.
  sequence s_quiet;
    !tx_valid [*8];
  endsequence

  property p_gcrc_first;
    @(posedge clk_sys) disable iff (!rst_n)
      gcrc_req |-> s_quiet;
  endproperty
  a_gcrc_first: assert property (p_gcrc_first) else $error("GoodCRC");

  property p_reset;
    @(posedge clk_sys)
      !rst_n |=> mode_entered_p == 3'h0 && mode_entered_pp == 3'h0 &&
                 !tx_valid && !gcrc_req;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");

endmodule : cpvdr_responder

/* File: cpvdr_partner.sv */
/*
  Far side model: physical layer and port partner timing for the
  discovery responder. Assumes the responder on the same clock.
*/
`timescale 1ns/1ns
module cpvdr_partner (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic gcrc_req,
  input wire logic tx_valid,
  input wire logic [3:0] tx_dly,
  output logic gcrc_done,
  output logic tx_done,
  output logic [19:0] gap
);
  logic [3:0] gc_q;
  logic [3:0] tc_q;
  logic [19:0] g_q;
  logic txv_q;
  // ----------------------------
  // Frame timing
  // ----------------------------
  // GoodCRC before reply
  always_ff @(posedge clk_sys) begin
    txv_q <= tx_valid;
    gcrc_done <= gc_q == 4'h1;
    tx_done <= tc_q == 4'h1;
    if (!rst_n) begin
      gc_q <= 4'h0;
      tc_q <= 4'h0;
      g_q <= 20'h00000;
      gap <= 20'h00000;
    end else begin
      gc_q <= gcrc_req ? 4'h3 : gc_q - {3'h0, gc_q != 4'h0};
      g_q <= gcrc_done ? 20'h00001 : g_q + {19'h0, g_q != 20'h0};
      // A slow far side holds the reply line busy for longer.
      if (tx_valid && !txv_q) begin
        tc_q <= tx_dly + 4'h1;
        gap <= g_q;
      end else begin
        tc_q <= tc_q - {3'h0, tc_q != 4'h0};
      end
    end
  end
endmodule : cpvdr_partner

/* File: test_cable_plug_vdm_discovery_responder.sv */
/*
  Self-checking bench of the cable plug discovery responder.
  Assumes the responder and the partner model compiled before it.
*/
`timescale 1ns/1ns
`include "cpvdr_defines.svh"
module test_cable_plug_vdm_discovery_responder;
  localparam int MINC = 20;
  localparam int MAXC = 100;
  localparam int WAITC = 50;
  localparam cpvdr_pkg::cpvdr_ctype_type ACK = cpvdr_pkg::CPVDR_ACK;
  localparam cpvdr_pkg::cpvdr_ctype_type NAK = cpvdr_pkg::CPVDR_NAK;
  localparam cpvdr_pkg::cpvdr_sop_type SP = cpvdr_pkg::CPVDR_SOP_P;
  localparam cpvdr_pkg::cpvdr_sop_type SPP = cpvdr_pkg::CPVDR_SOP_PP;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic dual_ctrl_present = 1'b0;
  logic modal_supported = 1'b1;
  logic rx_valid = 1'b0;
  cpvdr_pkg::cpvdr_rx_type rx_msg = '0;
  logic gcrc_done;
  logic tx_done;
  logic gcrc_req;
  logic tx_valid;
  cpvdr_pkg::cpvdr_tx_type tx_msg;
  logic [2:0] mode_entered_p;
  logic [2:0] mode_entered_pp;
  logic [3:0] tx_dly = 4'h1;
  logic [19:0] gap;
  int fails = 0;
  int n_compared = 0;
  int n_gcrc = 0;
  int cyc = 0;

  cpvdr_responder #(.REPLY_MIN_CYC(MINC), .REPLY_MAX_CYC(MAXC))
    cpvdr_responder_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .dual_ctrl_present(dual_ctrl_present),
    .modal_supported(modal_supported), .rx_valid(rx_valid),
    .rx_msg(rx_msg), .gcrc_done(gcrc_done), .tx_done(tx_done),
    .gcrc_req(gcrc_req), .tx_valid(tx_valid), .tx_msg(tx_msg),
    .mode_entered_p(mode_entered_p), .mode_entered_pp(mode_entered_pp));
  cpvdr_partner cpvdr_partner_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .gcrc_req(gcrc_req), .tx_valid(tx_valid), .tx_dly(tx_dly),
    .gcrc_done(gcrc_done), .tx_done(tx_done), .gap(gap));

  always #10 clk_sys = ~clk_sys;

  // A hung handshake ends the run instead of stalling it.
  always @(posedge clk_sys) begin
    cyc++;
    if (gcrc_req === 1'b1) n_gcrc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk_sys);
      #2;
      n++;
    end
  endtask : wait_lvl

  task automatic do_reset();
    @(posedge clk_sys);
    #2;
    rst_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    repeat (WAITC) @(posedge clk_sys);
  endtask : do_reset

  task automatic send(input cpvdr_pkg::cpvdr_sop_type s, input logic ok,
                      input logic [1:0] v, input logic [4:0] c,
                      input logic [2:0] p);
    @(posedge clk_sys);
    #2;
    rx_msg = '{s, ok, v, c, cpvdr_pkg::CPVDR_REQ, `CPVDR_SVID_VALUE, p};
    rx_valid = 1'b1;
    @(posedge clk_sys);
    #2;
    rx_valid = 1'b0;
    rx_msg = ~rx_msg;
  endtask : send

  task automatic xfer(input cpvdr_pkg::cpvdr_sop_type s,
                      input logic [1:0] v, input logic [4:0] c,
                      input logic [2:0] p, output cpvdr_pkg::cpvdr_tx_type r);
    for (int k = 0; k < 5; k++) begin
      send(s, 1'b1, v, c, p);
      wait_lvl(gcrc_req, 1'b1, 3);
      check({31'h0, gcrc_req & ~tx_valid}, 32'h1);
      wait_lvl(tx_valid, 1'b1, MAXC + 20);
      r = tx_msg;
      wait_lvl(tx_valid, 1'b0, 40);
      check({31'h0, gap >= MINC && gap <= MAXC}, 32'h1);
      check(r.sop, s);
      check(r.cmd, c);
      if (r.ctype !== cpvdr_pkg::CPVDR_BUSY) break;
      repeat (WAITC) @(posedge clk_sys);
    end
  endtask : xfer

  task automatic t_ident();
    cpvdr_pkg::cpvdr_tx_type r;
    for (int v = 0; v < 4; v++) begin
      xfer(SP, v[1:0], `CPVDR_CMD_DISC_ID, 3'h0, r);
      check(r.ctype, ACK);
      check(r.rev, `CPVDR_REV_20);
    end
  endtask : t_ident

  task automatic t_svid();
    cpvdr_pkg::cpvdr_tx_type r;
    modal_supported = 1'b0;
    xfer(SP, `CPVDR_REV_20, `CPVDR_CMD_DISC_SVID, 3'h0, r);
    check(r.ctype, NAK);
    check(r.modal, 1'b0);
    modal_supported = 1'b1;
    for (int n = 0; n < 4; n++) begin
      xfer(SP, `CPVDR_REV_20, `CPVDR_CMD_DISC_SVID, 3'h0, r);
      if (r.more_svids !== 1'b1) break;
    end
    check(r.ctype, ACK);
    check(r.svid, `CPVDR_SVID_VALUE);
    check(r.modal, 1'b1);
    xfer(SP, `CPVDR_REV_20, `CPVDR_CMD_DISC_MODE, 3'h0, r);
    check(r.ctype, ACK);
    check(r.obj_pos, `CPVDR_NUM_MODES);
    xfer(SP, `CPVDR_REV_20, 5'h1F, 3'h0, r);
    check(r.ctype, NAK);
  endtask : t_svid

  task automatic t_refuse();
    int n0;
    n0 = n_gcrc;
    send(cpvdr_pkg::CPVDR_SOP, 1'b1, `CPVDR_REV_20, `CPVDR_CMD_DISC_ID, 3'h0);
    send(SP, 1'b0, `CPVDR_REV_20, `CPVDR_CMD_DISC_ID, 3'h0);
    send(SPP, 1'b1, `CPVDR_REV_20, `CPVDR_CMD_DISC_ID, 3'h0);
    repeat (MAXC) @(posedge clk_sys);
    #2;
    check(n_gcrc, n0);
    check(tx_valid, 1'b0);
  endtask : t_refuse

  task automatic t_mode(input cpvdr_pkg::cpvdr_sop_type s);
    cpvdr_pkg::cpvdr_tx_type r;
    logic ok;
    tx_dly = 4'hE;
    for (int p = 1; p < 4; p++) begin
      ok = p <= `CPVDR_NUM_MODES;
      xfer(s, `CPVDR_REV_20, `CPVDR_CMD_ENTER, p[2:0], r);
      check(r.ctype, ok ? ACK : NAK);
      check(s == SP ? mode_entered_p : mode_entered_pp, ok ? p : 0);
      if (ok) begin
        xfer(s, `CPVDR_REV_20, `CPVDR_CMD_EXIT, p[2:0], r);
        check(r.ctype, ACK);
        check(s == SP ? mode_entered_p : mode_entered_pp, 0);
      end
    end
    tx_dly = 4'h1;
  endtask : t_mode

  task automatic t_vconn();
    cpvdr_pkg::cpvdr_tx_type r;
    xfer(SP, `CPVDR_REV_20, `CPVDR_CMD_ENTER, 3'h1, r);
    check(mode_entered_p, 3'h1);
    do_reset();
    #2;
    check(mode_entered_p, 3'h0);
    xfer(SP, `CPVDR_REV_20, `CPVDR_CMD_DISC_ID, 3'h0, r);
    check(r.ctype, ACK);
  endtask : t_vconn

  initial begin
    do_reset();
    t_ident();
    t_svid();
    t_refuse();
    t_mode(SP);
    dual_ctrl_present = 1'b1;
    repeat (4) @(posedge clk_sys);
    #2;
    t_mode(SPP);
    t_vconn();
    end_of_test();
  end
endmodule : test_cable_plug_vdm_discovery_responder
